// >>> include/atatf_pkg.sv
//----------------------------------------------------------------
// Purpose: constants and carriers for the task-file register set
// Assumes: 8-bit task-file registers on a 4-bit register offset
// Notes: offsets are the register addresses the host decodes
//----------------------------------------------------------------
package atatf_pkg;
    // register offsets
    localparam logic [3:0] OFS_ERROR = 4'h1;
    localparam logic [3:0] OFS_FEATURE = 4'h1;
    localparam logic [3:0] OFS_SECTOR_COUNT = 4'h2;
    localparam logic [3:0] OFS_SECTOR_NUMBER = 4'h3;
    localparam logic [3:0] OFS_CYLINDER_LOW = 4'h4;
    localparam logic [3:0] OFS_CYLINDER_HIGH = 4'h5;
    localparam logic [3:0] OFS_DEVICE_HEAD = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    localparam logic [3:0] OFS_COMMAND = 4'h7;
    localparam logic [3:0] OFS_ALT_STATUS = 4'hE;
    localparam logic [3:0] OFS_DEVICE_CONTROL = 4'hE;
    localparam logic [3:0] OFS_DRIVE_ADDRESS = 4'hF;
    // device/head fields
    localparam int DH_ONE_HI = 7;
    localparam int DH_LBA = 6;
    localparam int DH_ONE_LO = 5;
    localparam int DH_DRV = 4;
    // status fields
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_WRITE_FAULT = 5;
    localparam int ST_SEEK = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_CORRECTED_DATA_FLAG = 2;
    localparam int ST_ZERO = 1;
    localparam int ST_ERR = 0;
    // device control fields
    localparam int DC_SRST = 2;
    localparam int DC_NIEN = 1;
    // error fields
    localparam int ER_BBK = 7;
    localparam int ER_UNC = 6;
    localparam int ER_ID_NOT_FOUND_FLAG = 4;
    localparam int ER_ABORTED_FLAG = 2;
    localparam int ER_ADDRESS_MARK_MISSING_FLAG = 0;
    // reset values, forced device/head ones, full sector count and drive-address bit 7
    localparam logic [7:0] RST_TASK = 8'h00;
    localparam logic [7:0] RST_SECTOR_COUNT = 8'h01;
    localparam logic [7:0] RST_SECTOR_NUMBER = 8'h01;
    localparam logic [7:0] RST_DEVICE_HEAD = 8'hA0;
    localparam logic [7:0] DH_FORCED_ONES = 8'hA0;
    localparam logic [8:0] FULL_SECTOR_COUNT = 9'h100;
    localparam logic DA_UNDEFINED_BIT = 1'b1;

    typedef struct packed {
        logic busy;
        logic ready;
        logic write_fault;
        logic seek_done;
        logic data_request;
        logic corrected;
        logic cmd_error;
        logic bad_block;
        logic uncorrectable;
        logic id_not_found;
        logic aborted;
        logic address_mark_missing;
        logic write_active;
        logic drive_active;
        logic dma_phase;
        logic dma_want;
    } atatf_core_t;

    typedef struct packed {
        logic lba_mode;
        logic drive_select;
        logic [3:0] head;
        logic [27:0] lba;
        logic [15:0] cylinder;
        logic [7:0] sector;
        logic [8:0] sector_total;
        logic [7:0] feature;
    } atatf_task_t;

    typedef enum logic [2:0] {
        ATATF_IDLE = 3'b001,
        ATATF_CMD = 3'b010,
        ATATF_SRST = 3'b100
    } atatf_state_t;
endpackage

// >>> rtl/atatf_regs.sv
//----------------------------------------------------------------
// Purpose: task-file registers, status, interrupt and soft reset
// Assumes: host strobes are single-cycle and synchronous to mclk
// Notes: data register and command execution live elsewhere
//----------------------------------------------------------------
`timescale 1ns/1ns
module atatf_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // host register port
    input wire logic [3:0] host_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    // command engine side
    input wire atatf_pkg::atatf_core_t core_in,
    input wire logic core_done,
    input wire logic core_block_ready,
    input wire logic core_count_load,
    input wire logic [7:0] core_count_value,
    output logic cmd_strobe,
    output logic [7:0] cmd_code,
    output atatf_pkg::atatf_task_t task_out,
    output logic soft_reset,
    output logic intrq,
    output logic int_status_bit,
    output logic dma_request
);
    import atatf_pkg::*;

    //----------------------------------------------------------------
    // state
    //----------------------------------------------------------------
    atatf_state_t state_r, state_nxt;
    logic [7:0] feature_r, feature_nxt;
    logic [7:0] scount_r, scount_nxt;
    logic [7:0] sector_r, sector_nxt;
    logic [7:0] cyl_low_r, cyl_low_nxt;
    logic [7:0] cyl_high_r, cyl_high_nxt;
    logic [7:0] devhead_r, devhead_nxt;
    logic [7:0] error_r, error_nxt;
    logic srst_r, srst_nxt;
    logic nien_r, nien_nxt;
    logic pending_r, pending_nxt;
    logic intrq_r, intrq_nxt;
    logic int_status_r, int_status_nxt;
    logic dma_r, dma_nxt;
    logic cmd_strobe_r, cmd_strobe_nxt;
    logic [7:0] cmd_code_r, cmd_code_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    atatf_task_t task_r, task_nxt;
    logic busy_view;
    logic [7:0] status_view;
    logic [7:0] drive_addr_view;
    logic wr_task;

    //----------------------------------------------------------------
    // status and mirror views
    //----------------------------------------------------------------
    always_comb begin
        // busy also shown while command is handed over
        busy_view = core_in.busy || (state_r != ATATF_IDLE);
        status_view = 8'h00;
        status_view[ST_BUSY] = busy_view;
        status_view[ST_READY] = core_in.ready && !srst_r;
        status_view[ST_WRITE_FAULT] = core_in.write_fault;
        status_view[ST_SEEK] = core_in.seek_done;
        status_view[ST_DRQ] = core_in.data_request;
        status_view[ST_CORRECTED_DATA_FLAG] = core_in.corrected;
        // bit 1 zero, bit 0 error
        status_view[ST_ZERO] = 1'b0;
        status_view[ST_ERR] = core_in.cmd_error;
        drive_addr_view[7] = DA_UNDEFINED_BIT;
        drive_addr_view[6] = !core_in.write_active;
        drive_addr_view[5:2] = ~devhead_r[3:0];
        drive_addr_view[1] = !(core_in.drive_active && devhead_r[DH_DRV]);
        drive_addr_view[0] = !(core_in.drive_active && !devhead_r[DH_DRV]);
    end

    //----------------------------------------------------------------
    // next-state logic
    //----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        feature_nxt = feature_r;
        scount_nxt = scount_r;
        sector_nxt = sector_r;
        cyl_low_nxt = cyl_low_r;
        cyl_high_nxt = cyl_high_r;
        devhead_nxt = devhead_r;
        error_nxt = error_r;
        srst_nxt = srst_r;
        nien_nxt = nien_r;
        pending_nxt = pending_r;
        cmd_strobe_nxt = 1'b0;
        cmd_code_nxt = cmd_code_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = host_rd;
        wr_task = host_wr && !busy_view;

        if (host_rd && host_addr == OFS_STATUS) begin
            pending_nxt = 1'b0;
        end
        if (host_rd) begin
            case (host_addr)
                OFS_ERROR: rdata_nxt = error_r;
                OFS_SECTOR_COUNT: rdata_nxt = scount_r;
                OFS_SECTOR_NUMBER: rdata_nxt = sector_r;
                OFS_CYLINDER_LOW: rdata_nxt = cyl_low_r;
                OFS_CYLINDER_HIGH: rdata_nxt = cyl_high_r;
                OFS_DEVICE_HEAD: rdata_nxt = devhead_r;
                OFS_STATUS: rdata_nxt = status_view;
                OFS_ALT_STATUS: rdata_nxt = status_view;
                OFS_DRIVE_ADDRESS: rdata_nxt = drive_addr_view;
                default: rdata_nxt = RST_TASK;
            endcase
        end

        if (wr_task) begin
            case (host_addr)
                OFS_FEATURE: feature_nxt = host_wdata;
                OFS_SECTOR_COUNT: scount_nxt = host_wdata;
                OFS_SECTOR_NUMBER: sector_nxt = host_wdata;
                OFS_CYLINDER_LOW: cyl_low_nxt = host_wdata;
                OFS_CYLINDER_HIGH: cyl_high_nxt = host_wdata;
                // bits 7 and 5 kept at one
                OFS_DEVICE_HEAD: devhead_nxt = host_wdata | DH_FORCED_ONES;
                OFS_COMMAND: begin
                    cmd_strobe_nxt = 1'b1;
                    cmd_code_nxt = host_wdata;
                    pending_nxt = 1'b0;
                end
                default: begin
                end
            endcase
        end

        if (host_wr && host_addr == OFS_DEVICE_CONTROL) begin
            // soft reset held while bit set
            srst_nxt = host_wdata[DC_SRST];
            nien_nxt = host_wdata[DC_NIEN];
        end

        if (core_count_load) begin
            scount_nxt = core_count_value;
        end
        if (core_done) begin
            error_nxt = 8'h00;
            error_nxt[ER_BBK] = core_in.bad_block;
            error_nxt[ER_UNC] = core_in.uncorrectable;
            error_nxt[ER_ID_NOT_FOUND_FLAG] = core_in.id_not_found;
            error_nxt[ER_ABORTED_FLAG] = core_in.aborted;
            error_nxt[ER_ADDRESS_MARK_MISSING_FLAG] = core_in.address_mark_missing;
        end
        // completion sets interrupt only when enabled, set beats clear
        if ((core_done || core_block_ready) && !nien_r) begin
            pending_nxt = 1'b1;
        end

        case (state_r)
            ATATF_IDLE: begin
                if (cmd_strobe_nxt) begin
                    state_nxt = ATATF_CMD;
                end
            end
            ATATF_CMD: begin
                if (core_in.busy || core_done) begin
                    state_nxt = ATATF_IDLE;
                end
            end
            ATATF_SRST: begin
                if (!srst_nxt) begin
                    state_nxt = ATATF_IDLE;
                end
            end
            default: state_nxt = ATATF_IDLE;
        endcase

        // soft reset restores task file, keeps control
        if (srst_nxt) begin
            state_nxt = ATATF_SRST;
            feature_nxt = RST_TASK;
            scount_nxt = RST_SECTOR_COUNT;
            sector_nxt = RST_SECTOR_NUMBER;
            cyl_low_nxt = RST_TASK;
            cyl_high_nxt = RST_TASK;
            devhead_nxt = RST_DEVICE_HEAD;
            error_nxt = RST_TASK;
            pending_nxt = 1'b0;
            cmd_strobe_nxt = 1'b0;
        end

        intrq_nxt = pending_nxt && !nien_nxt;
        int_status_nxt = pending_nxt && !nien_nxt;
        // DMA request needs busy or data request
        dma_nxt = core_in.dma_phase && core_in.dma_want && (core_in.busy || core_in.data_request);

        task_nxt.lba_mode = devhead_nxt[DH_LBA];
        task_nxt.drive_select = devhead_nxt[DH_DRV];
        task_nxt.head = devhead_nxt[3:0];
        task_nxt.lba = {devhead_nxt[3:0], cyl_high_nxt, cyl_low_nxt, sector_nxt};
        task_nxt.cylinder = {cyl_high_nxt, cyl_low_nxt};
        task_nxt.sector = sector_nxt;
        task_nxt.sector_total = (scount_nxt == 8'h00) ? FULL_SECTOR_COUNT : {1'b0, scount_nxt};
        task_nxt.feature = feature_nxt;
    end

    //----------------------------------------------------------------
    // registers
    //----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ATATF_IDLE;
            feature_r <= RST_TASK;
            scount_r <= RST_SECTOR_COUNT;
            sector_r <= RST_SECTOR_NUMBER;
            cyl_low_r <= RST_TASK;
            cyl_high_r <= RST_TASK;
            devhead_r <= RST_DEVICE_HEAD;
            error_r <= RST_TASK;
            srst_r <= 1'b0;
            nien_r <= 1'b0;
            pending_r <= 1'b0;
            intrq_r <= 1'b0;
            int_status_r <= 1'b0;
            dma_r <= 1'b0;
            cmd_strobe_r <= 1'b0;
            cmd_code_r <= RST_TASK;
            rdata_r <= RST_TASK;
            rvalid_r <= 1'b0;
            task_r <= '0;
        end else begin
            state_r <= state_nxt;
            feature_r <= feature_nxt;
            scount_r <= scount_nxt;
            sector_r <= sector_nxt;
            cyl_low_r <= cyl_low_nxt;
            cyl_high_r <= cyl_high_nxt;
            devhead_r <= devhead_nxt;
            error_r <= error_nxt;
            srst_r <= srst_nxt;
            nien_r <= nien_nxt;
            pending_r <= pending_nxt;
            intrq_r <= intrq_nxt;
            int_status_r <= int_status_nxt;
            dma_r <= dma_nxt;
            cmd_strobe_r <= cmd_strobe_nxt;
            cmd_code_r <= cmd_code_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            task_r <= task_nxt;
        end
    end

    assign host_rdata = rdata_r;
    assign host_rvalid = rvalid_r;
    assign cmd_strobe = cmd_strobe_r;
    assign cmd_code = cmd_code_r;
    assign task_out = task_r;
    assign soft_reset = srst_r;
    assign intrq = intrq_r;
    assign int_status_bit = int_status_r;
    assign dma_request = dma_r;

    //----------------------------------------------------------------
    // assertions
    //----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    property p_status_read_clears;
        host_rd && host_addr == OFS_STATUS && !core_done && !core_block_ready |=> !intrq_r;
    endproperty
    a_status_read_clears: assert property (p_status_read_clears) else $error("status read left interrupt");

    property p_alt_read_keeps;
        host_rd && host_addr == OFS_ALT_STATUS && intrq_r && !host_wr |=> intrq_r;
    endproperty
    a_alt_read_keeps: assert property (p_alt_read_keeps) else $error("alt status read cleared interrupt");

    property p_zero_means_256;
        scount_r == 8'h00 |-> task_r.sector_total == FULL_SECTOR_COUNT;
    endproperty
    a_zero_means_256: assert property (p_zero_means_256) else $error("zero count not 256");

    property p_forced_ones;
        devhead_r[DH_ONE_HI] && devhead_r[DH_ONE_LO];
    endproperty
    a_forced_ones: assert property (p_forced_ones) else $error("device/head bit 7 or 5 clear");

    property p_lba_assembly;
        1'b1 |=> task_r.lba == {devhead_r[3:0], cyl_high_r, cyl_low_r, sector_r}
            && task_r.lba_mode == devhead_r[DH_LBA];
    endproperty
    a_lba_assembly: assert property (p_lba_assembly) else $error("address assembly wrong");

    property p_busy_lock;
        host_wr && host_addr == OFS_SECTOR_NUMBER && busy_view && !srst_nxt
            |=> sector_r == $past(sector_r);
    endproperty
    a_busy_lock: assert property (p_busy_lock) else $error("write taken while busy");

    property p_dma_gate;
        dma_request |-> $past(core_in.busy || core_in.data_request);
    endproperty
    a_dma_gate: assert property (p_dma_gate) else $error("dma request without busy or drq");

    property p_status_zero_bit;
        host_rd && host_addr == OFS_STATUS |=> host_rvalid && !host_rdata[ST_ZERO];
    endproperty
    a_status_zero_bit: assert property (p_status_zero_bit) else $error("status bit 1 not zero");

    property p_srst_held;
        host_wr && host_addr == OFS_DEVICE_CONTROL && host_wdata[DC_SRST]
            |=> soft_reset ##1 (soft_reset || $past(host_wr && host_addr == OFS_DEVICE_CONTROL));
    endproperty
    a_srst_held: assert property (p_srst_held) else $error("soft reset not held");

    property p_nien_gate;
        intrq_r |-> !nien_r && int_status_bit;
    endproperty
    a_nien_gate: assert property (p_nien_gate) else $error("interrupt while disabled");

    property p_drive_mirror;
        host_rd && host_addr == OFS_DRIVE_ADDRESS
            |=> host_rdata[5:2] == ~$past(devhead_r[3:0]) && host_rdata[6] == !$past(core_in.write_active);
    endproperty
    a_drive_mirror: assert property (p_drive_mirror) else $error("drive address mirror wrong");

    c_command: cover property (cmd_strobe ##[1:20] core_done);
    c_soft_reset: cover property (soft_reset ##[1:20] !soft_reset);
    c_interrupt: cover property (intrq_r ##[1:20] !intrq_r);
    c_dma: cover property (dma_request);
endmodule

// >>> verif/atatf_engine_model.sv
// Purpose: command engine stand-in behind the task-file registers
// Assumes: each taken command keeps the engine busy for a fixed span
// Notes: the bench steers status flags and the failure outcome
`timescale 1ns/1ns
module atatf_engine_model (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // steering from the bench
    input wire atatf_pkg::atatf_core_t base_flags,
    input wire logic fail_next,
    input wire logic [7:0] remain_count,
    // block side
    input wire logic cmd_strobe,
    output atatf_pkg::atatf_core_t core_in,
    output logic core_done,
    output logic core_count_load,
    output logic [7:0] core_count_value
);
    import atatf_pkg::*;
    logic [3:0] busy_cnt_r;
    logic err_r;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt_r <= 4'h0;
            err_r <= 1'b0;
        end else if (cmd_strobe) begin
            busy_cnt_r <= 4'h6;
            err_r <= fail_next;
        end else if (busy_cnt_r != 4'h0) begin
            busy_cnt_r <= busy_cnt_r - 4'h1;
        end
    end
    always_comb begin
        core_in = base_flags;
        core_in.busy = base_flags.busy | (busy_cnt_r != 4'h0);
        core_in.cmd_error = err_r;
        core_in.aborted = err_r;
        core_done = (busy_cnt_r == 4'h1);
        core_count_load = core_done;
        core_count_value = err_r ? remain_count : 8'h00;
    end
endmodule

// >>> verif/testbench.sv
// Purpose: self-checking bench for the task-file register set
// Assumes: host strobes driven on the falling edge of mclk
// Notes: the engine model supplies status and completions
`timescale 1ns/1ns
module testbench;
    import atatf_pkg::*;
    logic mclk, reset_n, host_rd, host_wr, host_rvalid, fail_next;
    logic cmd_strobe, soft_reset, intrq, int_status_bit, dma_request;
    logic core_done, core_count_load, block_ready;
    logic [3:0] host_addr;
    logic [7:0] host_wdata, host_rdata, cmd_code, core_count_value, remain_count, rd_val;
    atatf_core_t core_in, base_flags;
    atatf_task_t task_out;
    int n_mismatch, cmp_count, cycles;

    atatf_regs atatf_regs_inst (.mclk(mclk), .reset_n(reset_n), .host_addr(host_addr),
        .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .core_in(core_in), .core_done(core_done),
        .core_block_ready(block_ready), .core_count_load(core_count_load),
        .core_count_value(core_count_value), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
        .task_out(task_out), .soft_reset(soft_reset), .intrq(intrq),
        .int_status_bit(int_status_bit), .dma_request(dma_request));
    atatf_engine_model atatf_engine_model_inst (.mclk(mclk), .reset_n(reset_n),
        .base_flags(base_flags), .fail_next(fail_next), .remain_count(remain_count),
        .cmd_strobe(cmd_strobe), .core_in(core_in), .core_done(core_done),
        .core_count_load(core_count_load), .core_count_value(core_count_value));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            $display("[FAIL] %0t run did not finish", $time);
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
            n_mismatch = n_mismatch + 1;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge mclk);
        host_wr = 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(negedge mclk);
        host_addr = a;
        host_rd = 1'b1;
        @(negedge mclk);
        host_rd = 1'b0;
        chk(host_rvalid, 1, "read valid");
        rd_val = host_rdata;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        rd(a);
        chk(rd_val, exp, "register read");
    endtask

    task automatic wait_done();
        for (int i = 0; i < 50 && core_done !== 1'b1; i++) @(negedge mclk);
        chk(core_done, 1, "completion seen");
        repeat (2) @(negedge mclk);
    endtask

    task automatic t_reset();
        rchk(OFS_SECTOR_COUNT, 8'h01);
        rchk(OFS_SECTOR_NUMBER, 8'h01);
        rchk(OFS_DEVICE_HEAD, 8'hA0);
        rchk(OFS_ERROR, 8'h00);
        rchk(OFS_DRIVE_ADDRESS, 8'hFE);
        chk(intrq, 0, "irq idle");
    endtask

    task automatic t_addr();
        wr(OFS_FEATURE, 8'hC3);
        chk(task_out.feature, 8'hC3, "feature");
        wr(OFS_SECTOR_NUMBER, 8'h11);
        wr(OFS_CYLINDER_LOW, 8'h22);
        wr(OFS_CYLINDER_HIGH, 8'h33);
        wr(OFS_DEVICE_HEAD, 8'h45);
        rchk(OFS_DEVICE_HEAD, 8'hE5);
        chk(task_out.lba_mode, 1, "lba mode");
        chk(task_out.lba, 32'h5332211, "lba");
        wr(OFS_DEVICE_HEAD, 8'h13);
        rchk(OFS_DEVICE_HEAD, 8'hB3);
        chk({task_out.lba_mode, task_out.drive_select}, 2'b01, "chs drive1");
        chk({task_out.head, task_out.cylinder, task_out.sector}, 28'h3332211, "chs");
        rchk(OFS_DRIVE_ADDRESS, 8'hF1);
        wr(OFS_SECTOR_COUNT, 8'h00);
        chk(task_out.sector_total, 9'h100, "count zero");
        wr(OFS_DEVICE_HEAD, 8'hA0);
    endtask

    task automatic t_cmd_ok();
        wr(OFS_COMMAND, 8'h20);
        chk({cmd_strobe, cmd_code}, 9'h120, "command taken");
        rd(OFS_ALT_STATUS);
        chk(rd_val[7], 1, "busy on command");
        wait_done();
        chk({intrq, int_status_bit}, 2'b11, "irq raised");
        rchk(OFS_ALT_STATUS, 8'h50);
        chk(intrq, 1, "alt read keeps irq");
        rchk(OFS_STATUS, 8'h50);
        chk(intrq, 0, "status read clears");
        rchk(OFS_SECTOR_COUNT, 8'h00);
    endtask

    task automatic t_cmd_fail();
        fail_next = 1'b1;
        remain_count = 8'h03;
        wr(OFS_COMMAND, 8'h30);
        wait_done();
        rchk(OFS_ERROR, 8'h04);
        rchk(OFS_STATUS, 8'h51);
        rchk(OFS_SECTOR_COUNT, 8'h03);
        fail_next = 1'b0;
    endtask

    task automatic t_busy_refuse();
        wr(OFS_SECTOR_NUMBER, 8'h5A);
        wr(OFS_COMMAND, 8'h40);
        wr(OFS_SECTOR_NUMBER, 8'h99);
        wr(OFS_DEVICE_CONTROL, 8'hFB);
        chk(soft_reset, 0, "ignored bits");
        wait_done();
        chk({intrq, int_status_bit}, 2'b00, "irq disabled");
        rchk(OFS_SECTOR_NUMBER, 8'h5A);
        wr(OFS_DEVICE_CONTROL, 8'h00);
        @(negedge mclk);
        chk(intrq, 0, "dropped irq");
    endtask

    task automatic t_soft_reset();
        wr(OFS_DEVICE_CONTROL, 8'h04);
        chk(soft_reset, 1, "soft reset on");
        rd(OFS_STATUS);
        chk(rd_val[7:6], 2'b10, "busy in reset");
        wr(OFS_SECTOR_COUNT, 8'h77);
        repeat (3) @(negedge mclk);
        chk(soft_reset, 1, "reset held");
        wr(OFS_DEVICE_CONTROL, 8'h00);
        chk(soft_reset, 0, "soft reset off");
        rchk(OFS_SECTOR_COUNT, 8'h01);
        rchk(OFS_ERROR, 8'h00);
    endtask

    task automatic t_hw_reset_irq();
        wr(OFS_DEVICE_CONTROL, 8'h02);
        @(negedge mclk);
        reset_n = 1'b0;
        @(negedge mclk);
        reset_n = 1'b1;
        chk({soft_reset, intrq, host_rvalid}, 3'b000, "outputs after reset");
        @(negedge mclk);
        block_ready = 1'b1;
        @(negedge mclk);
        block_ready = 1'b0;
        chk(intrq, 1, "irq enabled after reset");
        @(negedge mclk);
        host_addr = OFS_STATUS;
        host_rd = 1'b1;
        block_ready = 1'b1;
        @(negedge mclk);
        host_rd = 1'b0;
        block_ready = 1'b0;
        chk(intrq, 1, "set beats status clear");
        rchk(OFS_STATUS, 8'h50);
        chk(intrq, 0, "status read clears");
    endtask

    task automatic t_flags_dma();
        base_flags.dma_phase = 1'b1;
        base_flags.dma_want = 1'b1;
        repeat (3) @(negedge mclk);
        chk(dma_request, 0, "dma held off");
        base_flags.data_request = 1'b1;
        base_flags.write_fault = 1'b1;
        base_flags.corrected = 1'b1;
        base_flags.write_active = 1'b1;
        repeat (3) @(negedge mclk);
        chk(dma_request, 1, "dma with drq");
        rchk(OFS_STATUS, 8'h7C);
        rchk(OFS_DRIVE_ADDRESS, 8'hBE);
    endtask

    initial begin
        {host_rd, host_wr, fail_next, block_ready, n_mismatch, cmp_count, cycles} = '0;
        host_addr = 4'h0;
        host_wdata = 8'h00;
        remain_count = 8'h00;
        base_flags = '0;
        base_flags.ready = 1'b1;
        base_flags.seek_done = 1'b1;
        base_flags.drive_active = 1'b1;
        reset_n = 1'b0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        t_reset();
        t_addr();
        t_cmd_ok();
        t_cmd_fail();
        t_busy_refuse();
        t_soft_reset();
        t_hw_reset_irq();
        t_flags_dma();
        final_report();
    end
endmodule
